/* File: core/plf_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef PLF_MAP_SVH
`define PLF_MAP_SVH
// ***********************************************
// Register indices (byte address = index * 4)
// ***********************************************
`define PLF_IDX_CMD 8'h00
`define PLF_IDX_STAT 8'h01
`define PLF_IDX_LED 8'h10
`define PLF_IDX_MAC 8'h15
// ***********************************************
// Field positions
// ***********************************************
`define PLF_MAC_BLK_BIT 3
`define PLF_MAC_SPD_LSB 0
`define PLF_LED3_LSB 12
`define PLF_LED2_LSB 8
`define PLF_LED1_LSB 4
`define PLF_LED0_LSB 0
`define PLF_CMD_SWRST_BIT 0
// ***********************************************
// Reset values
// ***********************************************
`define PLF_MAC_RST 16'h1046
`define PLF_MAC_SWCLR 16'h307F
`define PLF_SPD_RST 3'h6
`define PLF_LED_RST_S0 16'h101E
`define PLF_LED_RST_S1 16'h3777
`define PLF_LED_RST_S2 16'h7177
`define PLF_LED_RST_S3 16'h1777
// ***********************************************
// Timing
// ***********************************************
`define PLF_CLK_MHZ 100
`define PLF_BLINK_MS 42
`define PLF_BLINK_CYC (`PLF_BLINK_MS * `PLF_CLK_MHZ * 1000)
`define PLF_STRAP_WAIT 2'h2
`endif

/* File: core/plf_pkg.sv */
// Types shared by the LED function and MAC speed control block
package plf_pkg;
	// Link state as seen by the LED selectors
	typedef struct packed {
		logic up;
		logic [1:0] spd;
		logic fdx;
		logic mst;
		logic tx;
		logic rx;
		logic an;
	} plf_link_t;
	// One LED drive decision
	typedef struct packed {
		logic on;
		logic oe;
	} plf_led_t;
	// Link speed codes on the link state input
	typedef enum logic [1:0] {
		PLF_SPD_10,
		PLF_SPD_100,
		PLF_SPD_1000,
		PLF_SPD_NONE
	} plf_spd_t;
endpackage

/* File: core/plf_top.sv */
// LED function select and MAC side speed control behind AXI4-Lite
`timescale 1ns/1ps
`include "plf_map.svh"
module plf_top import plf_pkg::*; #(
	parameter int AW = 12,
	parameter int CNT_W = 23,
	parameter int BLINK_CYC = `PLF_BLINK_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] led_config_strap,
	input wire plf_link_t link_in,
	input wire logic rx_carrier_ext,
	output logic mac_carrier_ext,
	output logic [1:0] mac_speed,
	output logic mac_txclk_slow,
	output logic [3:1] led_on,
	output logic [3:1] led_oe
);
	// ***********************************************
	// Declarations
	// ***********************************************
	logic awready_ff; // Address slot free
	logic wready_ff; // Data slot free
	logic aw_got_ff; // Address held
	logic w_got_ff; // Data held
	logic [7:0] aw_idx_ff; // Held write index
	logic [31:0] wdata_ff; // Held write data
	logic [3:0] wstrb_ff; // Held byte strobes
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [15:0] mac_reg_ff; // MAC side control
	logic [15:0] led_reg_ff; // LED function select
	logic [2:0] spd_act_ff; // Applied default speed
	logic swrst_ff; // Soft reset pulse
	logic [1:0] strap_cnt_ff; // Wait for strap sync
	logic [1:0] strap_s1_ff; // Strap sync stage one
	logic [1:0] strap_s2_ff; // Strap sync stage two
	plf_link_t link_s1_ff; // Link sync stage one
	plf_link_t link_s2_ff; // Link sync stage two
	logic [CNT_W-1:0] blink_cnt_ff; // Blink period count
	logic blink_ff; // Blink phase
	logic carrier_ff;
	logic [1:0] speed_ff;
	logic txslow_ff;
	logic [3:1] led_on_ff;
	logic [3:1] led_oe_ff;
	logic wr_fire; // Address and data both held
	logic [15:0] wmask; // Byte lanes to write
	logic [15:0] nxt_led_rst; // Strap selected default
	plf_led_t led3_d;
	plf_led_t led2_d;
	plf_led_t led1_d;

	// ***********************************************
	// Output wiring
	// ***********************************************
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign mac_carrier_ext = carrier_ff;
	assign mac_speed = speed_ff;
	assign mac_txclk_slow = txslow_ff;
	assign led_on = led_on_ff;
	assign led_oe = led_oe_ff;

	// ***********************************************
	// AXI4-Lite write channel
	// ***********************************************
	assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
	assign wmask = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

	// Address capture, independent of data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b0;
			aw_got_ff <= 1'b0;
			aw_idx_ff <= 8'h00;
		end else if (clk_en) begin
			if (s_axi_awvalid && awready_ff) begin
				aw_got_ff <= 1'b1;
				aw_idx_ff <= s_axi_awaddr[9:2];
				awready_ff <= 1'b0;
			end else if (wr_fire) begin
				aw_got_ff <= 1'b0;
			end else begin
				// Ready only while the slot is empty
				awready_ff <= !aw_got_ff && !bvalid_ff;
			end
		end
	end

	// Data capture, independent of address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_ff <= 1'b0;
			w_got_ff <= 1'b0;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end else if (clk_en) begin
			if (s_axi_wvalid && wready_ff) begin
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
				wready_ff <= 1'b0;
			end else if (wr_fire) begin
				w_got_ff <= 1'b0;
			end else begin
				wready_ff <= !w_got_ff && !bvalid_ff;
			end
		end
	end

	// Write response, error for unmapped index
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'h0;
		end else if (clk_en) begin
			if (wr_fire) begin
				bvalid_ff <= 1'b1;
				case (aw_idx_ff)
					`PLF_IDX_CMD, `PLF_IDX_STAT,
					`PLF_IDX_LED, `PLF_IDX_MAC: bresp_ff <= 2'h0;
					default: bresp_ff <= 2'h2;
				endcase
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// ***********************************************
	// AXI4-Lite read channel
	// ***********************************************
	// One read at a time; data one cycle after address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= 2'h0;
		end else if (clk_en) begin
			if (s_axi_arvalid && arready_ff) begin
				arready_ff <= 1'b0;
				rvalid_ff <= 1'b1;
				rresp_ff <= 2'h0;
				case (s_axi_araddr[9:2])
					`PLF_IDX_CMD: rdata_ff <= 32'h00000000;
					// Status shows live link and applied speed
					`PLF_IDX_STAT: rdata_ff <= {21'h00000, spd_act_ff, link_s2_ff};
					`PLF_IDX_LED: rdata_ff <= {16'h0000, led_reg_ff};
					`PLF_IDX_MAC: rdata_ff <= {16'h0000, mac_reg_ff};
					default: begin
						rdata_ff <= 32'h00000000;
						rresp_ff <= 2'h2;
					end
				endcase
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end else begin
				arready_ff <= !rvalid_ff;
			end
		end
	end

	// ***********************************************
	// Soft reset command
	// ***********************************************
	// Write one to the command bit for a one cycle pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			swrst_ff <= 1'b0;
		end else if (clk_en) begin
			swrst_ff <= wr_fire && (aw_idx_ff == `PLF_IDX_CMD) && wstrb_ff[0] &&
				wdata_ff[`PLF_CMD_SWRST_BIT];
		end
	end

	// ***********************************************
	// MAC side control register
	// ***********************************************
	// Reserved bits are plain storage; software keeps them right
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mac_reg_ff <= `PLF_MAC_RST;
		end else if (clk_en) begin
			if (wr_fire && aw_idx_ff == `PLF_IDX_MAC) begin
				mac_reg_ff <= (mac_reg_ff & ~wmask) | (wdata_ff[15:0] & wmask);
			end else if (swrst_ff) begin
				// Soft reset clears the fields that do not retain
				mac_reg_ff <= mac_reg_ff & `PLF_MAC_SWCLR;
			end
		end
	end

	// Applied speed moves only on soft reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			spd_act_ff <= `PLF_SPD_RST;
		end else if (clk_en && swrst_ff) begin
			spd_act_ff <= mac_reg_ff[`PLF_MAC_SPD_LSB +: 3];
		end
	end

	// ***********************************************
	// Link state synchroniser
	// ***********************************************
	// Two stages; only stage two feeds any logic
	always_ff @(posedge aclk) begin
		if (clk_en) begin
			link_s1_ff <= link_in;
			link_s2_ff <= link_s1_ff;
			strap_s1_ff <= led_config_strap;
			strap_s2_ff <= strap_s1_ff;
		end
	end

	// ***********************************************
	// MAC interface outputs
	// ***********************************************
	// Carrier extension passed unless blocked
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			carrier_ff <= 1'b0;
		end else if (clk_en) begin
			carrier_ff <= rx_carrier_ext && !mac_reg_ff[`PLF_MAC_BLK_BIT];
		end
	end

	// Speed: link speed when up, default when down under autoneg
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			speed_ff <= PLF_SPD_1000;
			txslow_ff <= 1'b1;
		end else if (clk_en) begin
			if (link_s2_ff.up || !link_s2_ff.an) begin
				speed_ff <= link_s2_ff.spd;
				txslow_ff <= 1'b0;
			end else begin
				// Upper codes carry the slow transmit clock flag
				txslow_ff <= spd_act_ff[2];
				case (spd_act_ff)
					3'h0: speed_ff <= PLF_SPD_10;
					3'h1: speed_ff <= PLF_SPD_100;
					3'h4: speed_ff <= PLF_SPD_100;
					default: speed_ff <= PLF_SPD_1000;
				endcase
			end
		end
	end

	// ***********************************************
	// LED function register and strap load
	// ***********************************************
	always_comb begin
		case (strap_s2_ff)
			2'h0: nxt_led_rst = `PLF_LED_RST_S0;
			2'h1: nxt_led_rst = `PLF_LED_RST_S1;
			2'h2: nxt_led_rst = `PLF_LED_RST_S2;
			default: nxt_led_rst = `PLF_LED_RST_S3;
		endcase
	end

	// Strap is loaded once the synchroniser has filled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_cnt_ff <= `PLF_STRAP_WAIT;
		end else if (clk_en && strap_cnt_ff != 2'h0) begin
			strap_cnt_ff <= strap_cnt_ff - 2'h1;
		end
	end

	// Soft reset leaves the fields untouched
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			led_reg_ff <= 16'h0000;
		end else if (clk_en) begin
			if (strap_cnt_ff == 2'h1) begin
				led_reg_ff <= nxt_led_rst;
			end else if (wr_fire && aw_idx_ff == `PLF_IDX_LED) begin
				led_reg_ff <= (led_reg_ff & ~wmask) | (wdata_ff[15:0] & wmask);
			end
		end
	end

	// ***********************************************
	// Blink generator
	// ***********************************************
	// One shared phase keeps all blinking LEDs in step
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			blink_cnt_ff <= '0;
			blink_ff <= 1'b0;
		end else if (clk_en) begin
			if (blink_cnt_ff == CNT_W'(BLINK_CYC - 1)) begin
				blink_cnt_ff <= '0;
				blink_ff <= !blink_ff;
			end else begin
				blink_cnt_ff <= blink_cnt_ff + 1'b1;
			end
		end
	end

	// ***********************************************
	// LED function decode
	// ***********************************************
	// Evaluates one LED; idx picks the per-output variants
	function automatic plf_led_t led_eval(input logic [3:0] code, input int idx,
		input plf_link_t lk, input logic blk);
		plf_led_t r;
		logic act;
		logic s10;
		logic s100;
		logic s1000;
		r.on = 1'b0;
		r.oe = 1'b1;
		act = lk.tx || lk.rx;
		s10 = lk.up && (lk.spd == PLF_SPD_10);
		s100 = lk.up && (lk.spd == PLF_SPD_100);
		s1000 = lk.up && (lk.spd == PLF_SPD_1000);
		case (code)
			4'h0: r.on = (idx == 2) && lk.up;
			4'h1: r.on = lk.up && (act ? blk : 1'b1);
			4'h2: r.on = (idx != 2) && lk.up && (lk.rx ? blk : 1'b1);
			4'h3: r.on = act;
			4'h4: r.on = act && blk;
			4'h5: r.on = (idx != 1) && lk.tx;
			4'h6: begin
				if (idx == 3) begin
					r.on = s10 || (s1000 && lk.mst);
				end else if (idx == 2) begin
					r.on = s10 || s1000;
				end else begin
					r.on = s100 || s1000;
				end
			end
			4'h7: begin
				if (idx == 3) begin
					r.on = lk.up && lk.fdx;
				end else if (idx == 2) begin
					r.on = s10;
				end else begin
					r.on = s100;
				end
			end
			4'h8: r.on = 1'b0;
			4'h9: r.on = 1'b1;
			4'hA: begin
				if (idx == 3) begin
					r.on = blk;
				end else begin
					r.oe = 1'b0;
				end
			end
			4'hB: r.on = (idx != 3) && blk;
			// Dual modes and reserved codes leave it dark
			default: r.on = 1'b0;
		endcase
		return r;
	endfunction

	always_comb begin
		led3_d = led_eval(led_reg_ff[`PLF_LED3_LSB +: 4], 3, link_s2_ff, blink_ff);
		led2_d = led_eval(led_reg_ff[`PLF_LED2_LSB +: 4], 2, link_s2_ff, blink_ff);
		led1_d = led_eval(led_reg_ff[`PLF_LED1_LSB +: 4], 1, link_s2_ff, blink_ff);
		// LED3 handed to the dual pairing of LED2
		if (led_reg_ff[11:10] == 2'h3) begin
			led3_d = '{on: 1'b0, oe: 1'b1};
		end
		// LED1 handed to the dual pairing of LED0
		if (led_reg_ff[3:2] == 2'h3) begin
			led1_d = '{on: 1'b0, oe: 1'b1};
		end
	end

	// Registered LED drive
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			led_on_ff <= 3'h0;
			led_oe_ff <= 3'h7;
		end else if (clk_en) begin
			led_on_ff <= {led3_d.on, led2_d.on, led1_d.on};
			led_oe_ff <= {led3_d.oe, led2_d.oe, led1_d.oe};
		end
	end
endmodule

/* File: verification/plf_far_model.sv */
// Far-side model: PHY status source feeding the block's link inputs
`timescale 1ns/1ps
module plf_far_model import plf_pkg::*; (
	input wire logic aclk,
	input wire plf_link_t want,
	input wire logic ext_want,
	output plf_link_t link_in,
	output logic rx_carrier_ext
);
	// Link state moves only on clock edges, as a PHY core reports it
	always_ff @(posedge aclk) begin
		link_in <= want;
	end
	// Carrier extension source, raised only while the bench asks for it
	always_ff @(posedge aclk) begin
		rx_carrier_ext <= ext_want;
	end
endmodule

/* File: verification/plf_top_checker.sv */
// Port-level assertions for the LED function and MAC speed block
`timescale 1ns/1ps
module plf_top_checker import plf_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire plf_link_t link_in,
	input wire logic rx_carrier_ext,
	input wire logic mac_carrier_ext,
	input wire logic [1:0] mac_speed,
	input wire logic [3:1] led_on,
	input wire logic [3:1] led_oe
);
	// One clock domain, so one default clock and reset
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	carrier_gate_a: assert property (mac_carrier_ext |-> $past(rx_carrier_ext))
		else $error("carrier extension seen without a source");
	reset_state_a: assert property ($rose(aresetn) |-> mac_speed == 2'h2 && led_on == 3'h0)
		else $error("wrong output state after reset");
	// Six stable cycles cover the two sync stages and the output register
	// A frozen clock enable holds the old speed, so only enabled cycles count
	link_speed_a: assert property ((link_in.up && $stable(link_in) && clk_en) [*6] |-> mac_speed == link_in.spd)
		else $error("speed does not follow an up link");
	speed_code_a: assert property (mac_speed != 2'h3)
		else $error("undefined speed code");
	// Both slots fill at the handshake edge, the response registers one edge later
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write not answered within two cycles");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready)
		else $error("read not answered next cycle");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before taken");
endmodule
bind plf_top plf_top_checker chk_i (.aclk, .aresetn, .clk_en, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .link_in, .rx_carrier_ext, .mac_carrier_ext, .mac_speed, .led_on, .led_oe);

/* File: verification/test_phy_led_function_and_mac_speed_ctrl.sv */
// Self-checking bench for the LED function and MAC speed block
`timescale 1ns/1ps
module test_phy_led_function_and_mac_speed_ctrl import plf_pkg::*;;
	// ***********************************************
	// Signals
	// ***********************************************
	logic aclk;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = '0;
	logic [11:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, mac_speed, prev, r;
	logic [31:0] s_axi_rdata, q;
	logic mac_carrier_ext, mac_txclk_slow, rx_carrier_ext;
	logic ext_want = 1'b0;
	logic clk_en = 1'b1; // Freeze control
	logic [1:0] strap = 2'h0; // LED configuration strap level
	logic [3:1] led_on, led_oe, hi, lo;
	plf_link_t want = 8'h01, link_in;
	int fails = 0, n_tests = 0;
	// LED register, link state, expected lit and driven sets
	logic [29:0] rows [12] = '{{16'h6070, 8'h91, 3'h6, 3'h7}, {16'h7660, 8'hC9, 3'h3, 3'h7},
		{16'h9A80, 8'h91, 3'h4, 3'h5}, {16'h9C00, 8'h91, 3'h0, 3'h7},
		{16'h009C, 8'h91, 3'h2, 3'h7}, {16'h7776, 8'hB1, 3'h5, 3'h7},
		{16'h3350, 8'h95, 3'h6, 3'h7}, {16'h5530, 8'h95, 3'h7, 3'h7},
		{16'h1110, 8'h91, 3'h7, 3'h7}, {16'h2020, 8'h91, 3'h7, 3'h7},
		{16'h1010, 8'h01, 3'h0, 3'h7}, {16'h4440, 8'h91, 3'h0, 3'h7}};
	// Link-down default code, expected speed and slow clock flag
	logic [5:0] sp [4] = '{6'b000_00_0, 6'b001_01_0, 6'b100_01_1, 6'b110_10_1};
	// Configurations whose outputs must toggle
	logic [23:0] bl [3] = '{{16'hABB0, 8'h91}, {16'h1110, 8'h95}, {16'h4440, 8'h95}};
	// ***********************************************
	// Design, far side and clock
	// ***********************************************
	// Short blink period keeps toggling visible in a few dozen cycles
	plf_top #(.BLINK_CYC(8)) uut (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .led_config_strap(strap), .link_in, .rx_carrier_ext,
		.mac_carrier_ext, .mac_speed, .mac_txclk_slow, .led_on, .led_oe);
	plf_far_model far (.aclk, .want, .ext_want, .link_in, .rx_carrier_ext);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// ***********************************************
	// Tasks
	// ***********************************************
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", s, exp, seen);
		end
	endtask
	// Waits n edges, then settles at the falling edge for sampling
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask
	// One AXI4-Lite write (w=1) or read; handshakes judged mid-cycle to avoid edge races
	task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic [1:0] rs, input int hold = 0);
		bit ta, tw, td;
		int n;
		ta = 0;
		tw = 0;
		td = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		// A nonzero hold raises the response ready only that many cycles after the transfer starts
		s_axi_bready <= w && hold == 0;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w && hold == 0;
		for (n = 0; n < 64 && !td; n++) begin
			@(negedge aclk);
			ta = w ? (s_axi_awvalid && s_axi_awready) : (s_axi_arvalid && s_axi_arready);
			tw = s_axi_wvalid && s_axi_wready;
			td = w ? (s_axi_bvalid && s_axi_bready) : (s_axi_rvalid && s_axi_rready);
			rd = s_axi_rdata;
			rs = w ? s_axi_bresp : s_axi_rresp;
			@(posedge aclk);
			if (ta) begin
				s_axi_awvalid <= 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (tw) s_axi_wvalid <= 1'b0;
			if (n + 1 == hold) begin
				s_axi_bready <= w;
				s_axi_rready <= !w;
			end
			if (td) begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
			end
		end
		// Hung handshake ends the run
		if (!td) begin
			fails++;
			close_out();
		end
	endtask
	// ***********************************************
	// Main sequence
	// ***********************************************
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		wt(0);
		chk("speed rst", mac_speed, 2'h2);
		chk("slow rst", mac_txclk_slow, 1'b1);
		wt(4);
		bus(0, 12'h054, 0, q, r);
		chk("mac reg", q, 32'h1046);
		bus(0, 12'h040, 0, q, r);
		chk("led reg", q, 32'h101E);
		bus(0, 12'h008, 0, q, r);
		chk("bad read data", q, 32'h0);
		chk("bad read resp", r, 2'h2);
		// Late response ready: the error response must stand until taken
		bus(1, 12'h00C, 32'hFFFF, q, r, 3);
		chk("bad write", r, 2'h2);
		// Steady LED functions
		foreach (rows[i]) begin
			@(posedge aclk);
			want <= rows[i][13:6];
			bus(1, 12'h040, rows[i][29:14], q, r);
			wt(8);
			chk("led_on", led_on, rows[i][5:3]);
			chk("led_oe", led_oe, rows[i][2:0]);
		end
		// Blinking functions must show both levels
		foreach (bl[i]) begin
			@(posedge aclk);
			want <= bl[i][7:0];
			bus(1, 12'h040, bl[i][23:8], q, r);
			wt(6);
			hi = '0;
			lo = '0;
			repeat (40) begin
				@(negedge aclk);
				hi = hi | led_on;
				lo = lo | ~led_on;
			end
			chk("blink", {hi, lo}, 6'h3F);
		end
		// Carrier extension pass and block, link down with autoneg
		@(posedge aclk);
		want <= 8'h01;
		ext_want <= 1'b1;
		wt(4);
		chk("ext pass", mac_carrier_ext, 1'b1);
		bus(1, 12'h054, 32'h104E, q, r);
		wt(2);
		chk("ext block", mac_carrier_ext, 1'b0);
		// New default speed waits for soft reset
		prev = 2'h2;
		foreach (sp[i]) begin
			bus(1, 12'h054, 32'h1048 | sp[i][5:3], q, r);
			wt(4);
			chk("speed held", mac_speed, prev);
			bus(1, 12'h000, 32'h1, q, r);
			wt(4);
			chk("speed", mac_speed, sp[i][2:1]);
			chk("slow clk", mac_txclk_slow, sp[i][0]);
			prev = sp[i][2:1];
		end
		bus(0, 12'h054, 0, q, r);
		chk("mac kept", q, 32'h104E);
		@(posedge aclk);
		want <= 8'hB1;
		wt(8);
		chk("link speed", mac_speed, 2'h1);
		// Status shows applied default code 110b beside the synced link
		bus(0, 12'h004, 0, q, r);
		chk("status", q, 32'h6B1);
		// Clock enable low freezes the speed output against a link change
		@(posedge aclk);
		clk_en <= 1'b0;
		want <= 8'hC9;
		wt(8);
		chk("frozen", mac_speed, 2'h1);
		@(posedge aclk);
		clk_en <= 1'b1;
		wt(8);
		chk("thawed", mac_speed, 2'h2);
		// Second hardware reset mid-run
		@(posedge aclk);
		aresetn <= 1'b0;
		// Another strap level picks another LED default
		strap <= 2'h2;
		wt(3);
		@(posedge aclk);
		aresetn <= 1'b1;
		wt(4);
		chk("ext unblocked", mac_carrier_ext, 1'b1);
		bus(0, 12'h054, 0, q, r);
		chk("mac rst2", q, 32'h1046);
		// Late read ready: data must stand until taken
		bus(0, 12'h040, 0, q, r, 4);
		chk("led rst2", q, 32'h7177);
		close_out();
	end
endmodule
